// [hdl/csf_debounce.sv]
`default_nettype none
module csf_debounce #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned COUNT = 200
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);
  localparam int unsigned CW = $clog2(COUNT + 1);
  if (WIDTH < 1 || COUNT < 1) begin : g_bad_params
    $error("csf_debounce: bad parameters");
  end
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic out_reg;
    logic [CW-1:0] cnt_reg;
    wire differs = s2_reg != out_reg;
    wire expired = cnt_reg == CW'(COUNT - 1);
    // Two flops bring the flag in, then a stable count qualifies it.
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        out_reg <= 1'b0;
        cnt_reg <= '0;
      end else begin
        s1_reg <= raw[i];
        s2_reg <= s1_reg;
        cnt_reg <= (differs && !expired) ? CW'(cnt_reg + 1'b1) : '0;
        if (differs && expired) begin
          out_reg <= s2_reg;
        end
      end
    end
    assign clean[i] = out_reg;
  end
endmodule
`default_nettype wire

// [hdl/csf_pkg.sv]
`default_nettype none
package csf_pkg;
  // Clock and timing.
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned PULSE_US = 128;
  localparam int unsigned PULSE_CYC = (PULSE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DGL_US = 10;
  localparam int unsigned DGL_CYC = (DGL_US * (CLK_HZ / 1_000_000));
  // Input management threshold code: 4.2 V to 4.9 V in 100 mV steps, plus disable.
  localparam int unsigned INMGT_BASE_MV = 4200;
  localparam int unsigned INMGT_STEP_MV = 100;
  localparam logic [2:0] INMGT_MAX_CODE = 3'h7;
  localparam logic [3:0] INMGT_DISABLE = 4'h8;
  // Termination current span in microamperes.
  localparam logic [15:0] TERM_MIN_UA = 16'h01f4;
  localparam logic [15:0] TERM_MAX_UA = 16'h9088;
  localparam logic [15:0] TERM_DEFAULT_UA = 16'h07d0;
  // Fault codes.
  localparam logic [1:0] FAULT_NONE = 2'h0;
  localparam logic [1:0] FAULT_OVP = 2'h1;
  localparam logic [1:0] FAULT_UVLO = 2'h2;
  localparam logic [1:0] FAULT_SLEEP = 2'h3;

  typedef enum logic [2:0] {
    CSF_IDLE, CSF_INHIBIT, CSF_CC, CSF_CV, CSF_DONE, CSF_SLEEP, CSF_FAULT
  } csf_state_e;

  // Analog comparator flags.
  typedef struct packed {
    logic in_above_uvlo;
    logic in_above_ovp;
    logic in_above_bat_slp;
    logic in_at_mgmt;
    logic bat_at_reg;
    logic cur_at_term;
    logic bat_above_rechg;
    logic mid_below_power_path_loop;
    logic chg_cur_zero;
    logic mid_below_bsup1;
    logic mid_above_bsup2;
    logic in_limit_active;
  } csf_comp_s;

  typedef struct packed {
    logic sleep;
    logic ovp;
    logic uvlo;
  } csf_cond_s;
endpackage
`default_nettype wire

// [hdl/csf_top.sv]
`default_nettype none
module csf_top #(
  parameter int unsigned DGL_CYCLES = csf_pkg::DGL_CYC,
  parameter int unsigned PULSE_CYCLES = csf_pkg::PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire csf_pkg::csf_comp_s comp_raw,
  input wire logic charge_disable_pin,
  input wire logic charge_inhibit_bit,
  input wire logic term_enable,
  input wire logic double_timer_option,
  input wire logic [3:0] input_mgmt_threshold,
  input wire logic host_write,
  input wire logic reset_bit_write,
  input wire logic fault_read,
  input wire logic charge_current_pin_gnd,
  input wire logic input_limit_pin_gnd,
  input wire logic term_pin_gnd,
  input wire logic [15:0] pre_term_setting,
  input wire logic [15:0] term_current_external,
  output logic event_pulse,
  output logic [1:0] fault_code,
  output csf_pkg::csf_state_e charge_state,
  output logic input_mgmt_flag,
  output logic discharge_path_on,
  output logic charge_switch_on,
  output logic cc_mode,
  output logic cv_mode,
  output logic charge_reduce,
  output logic supplement_on,
  output logic timer_tick,
  output logic default_mode,
  output logic use_default_settings,
  output logic [15:0] term_current,
  output logic [15:0] precharge_current,
  output logic [12:0] input_mgmt_mv,
  output logic input_mgmt_enabled
);
  localparam int unsigned PW = $clog2(PULSE_CYCLES + 1);
  if (PULSE_CYCLES < 1 || DGL_CYCLES < 1) begin : g_bad_counts
    $error("csf_top: cycle counts must be at least one");
  end

  // Comparator flags debounced before use.
  logic [11:0] comp_clean;
  csf_debounce #(.WIDTH(12), .COUNT(DGL_CYCLES)) u_dbnc (
    .core_clk(core_clk),
    .resetn(resetn),
    .raw(comp_raw),
    .clean(comp_clean)
  );
  csf_pkg::csf_comp_s c;
  assign c = comp_clean;

  // Input condition decode.
  wire cond_ovp = c.in_above_uvlo && c.in_above_ovp;
  wire cond_uvlo = !c.in_above_uvlo;
  wire cond_sleep = c.in_above_uvlo && !c.in_above_bat_slp && !c.in_above_ovp;
  wire mgmt_en = !input_mgmt_threshold[3];
  wire mgmt_active = mgmt_en && c.in_at_mgmt;
  wire input_valid = c.in_above_uvlo && c.in_above_bat_slp && !c.in_above_ovp && !mgmt_active;
  wire charge_allowed = !charge_inhibit_bit && !charge_disable_pin;

  csf_pkg::csf_cond_s cond_now;
  csf_pkg::csf_cond_s cond_prev_reg;
  assign cond_now = '{sleep: cond_sleep, ovp: cond_ovp, uvlo: cond_uvlo};
  wire [2:0] cond_rise = cond_now & ~cond_prev_reg;
  wire any_rise = |cond_rise;

  // Supplement hysteresis and power-path loop.
  logic supp_reg;
  wire supp_next = supp_reg ? !c.mid_above_bsup2 : (c.mid_below_power_path_loop && c.chg_cur_zero
    && c.mid_below_bsup1);
  wire power_path_loop_active = c.mid_below_power_path_loop;
  wire other_loop = mgmt_active || power_path_loop_active || supp_reg || c.in_limit_active;

  // Charge state machine.
  csf_pkg::csf_state_e state_reg;
  csf_pkg::csf_state_e state_next;
  wire term_hit = term_enable && !other_loop && c.cur_at_term && c.bat_above_rechg;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      csf_pkg::CSF_IDLE: begin
        if (input_valid) begin
          state_next = charge_allowed ? csf_pkg::CSF_CC : csf_pkg::CSF_INHIBIT;
        end
      end
      csf_pkg::CSF_INHIBIT: begin
        if (charge_allowed) begin
          state_next = csf_pkg::CSF_CC;
        end
      end
      csf_pkg::CSF_CC: begin
        if (!charge_allowed) begin
          state_next = csf_pkg::CSF_INHIBIT;
        end else if (c.bat_at_reg) begin
          state_next = csf_pkg::CSF_CV;
        end
      end
      csf_pkg::CSF_CV: begin
        if (!charge_allowed) begin
          state_next = csf_pkg::CSF_INHIBIT;
        end else if (term_hit) begin
          state_next = csf_pkg::CSF_DONE;
        end else if (!c.bat_at_reg) begin
          state_next = csf_pkg::CSF_CC;
        end
      end
      csf_pkg::CSF_DONE: begin
        if (!charge_allowed) begin
          state_next = csf_pkg::CSF_INHIBIT;
        end else if (!c.bat_above_rechg) begin
          state_next = csf_pkg::CSF_CC;
        end
      end
      csf_pkg::CSF_SLEEP: begin
        if (c.in_above_bat_slp) begin
          state_next = csf_pkg::CSF_IDLE;
        end
      end
      csf_pkg::CSF_FAULT: begin
        if (!cond_ovp && !cond_uvlo) begin
          state_next = csf_pkg::CSF_IDLE;
        end
      end
      default: begin
        state_next = csf_pkg::CSF_IDLE;
      end
    endcase
    if (cond_ovp || cond_uvlo) begin
      state_next = csf_pkg::CSF_FAULT;
    end else if (cond_sleep) begin
      state_next = csf_pkg::CSF_SLEEP;
    end
  end

  // Fault code latch: a new event wins over a read.
  logic [1:0] fault_reg;
  wire fault_clear = fault_read && !cond_now[0] && !cond_now[1] && !cond_now[2];
  wire [1:0] fault_new = cond_rise[1] ? csf_pkg::FAULT_OVP :
    (cond_rise[0] ? csf_pkg::FAULT_UVLO : csf_pkg::FAULT_SLEEP);
  wire [1:0] fault_next = any_rise ? fault_new :
    (fault_clear ? csf_pkg::FAULT_NONE : fault_reg);

  // Each event starts or restarts a pulse, timed by a counter.
  logic [PW-1:0] pulse_cnt_reg;
  wire pulse_busy = pulse_cnt_reg != '0;
  wire [PW-1:0] pulse_cnt_next = any_rise ? PW'(PULSE_CYCLES) :
    (pulse_busy ? PW'(pulse_cnt_reg - 1'b1) : '0);

  // Safety timer tick at half rate with the double timer option while another loop is active.
  logic half_reg;
  wire slow = double_timer_option && (other_loop || mgmt_active);
  wire charging = (state_reg == csf_pkg::CSF_CC) || (state_reg == csf_pkg::CSF_CV);
  wire tick_next = charging && (!slow || half_reg);

  // Default versus host mode.
  logic dflt_reg;
  logic valid_prev_reg;
  wire dflt_next = (input_valid && !valid_prev_reg) || reset_bit_write ? 1'b1 :
    (host_write ? 1'b0 : dflt_reg);
  wire any_gnd = charge_current_pin_gnd || input_limit_pin_gnd || term_pin_gnd;
  wire use_dflt = dflt_reg && any_gnd;

  // Termination and pre-charge current selection.
  wire [15:0] term_src = (dflt_reg && !use_dflt) ? term_current_external :
    pre_term_setting;
  wire [15:0] term_clip = term_src < csf_pkg::TERM_MIN_UA ? csf_pkg::TERM_MIN_UA :
    (term_src > csf_pkg::TERM_MAX_UA ? csf_pkg::TERM_MAX_UA : term_src);
  wire [15:0] term_sel = use_dflt ? csf_pkg::TERM_DEFAULT_UA : term_clip;

  wire [12:0] mgmt_mv = 13'(csf_pkg::INMGT_BASE_MV +
    csf_pkg::INMGT_STEP_MV * int'(input_mgmt_threshold[2:0]));

  wire dis_next = (state_reg == csf_pkg::CSF_SLEEP) || (state_reg == csf_pkg::CSF_FAULT
    && cond_ovp) || state_reg == csf_pkg::CSF_IDLE || supp_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= csf_pkg::CSF_IDLE;
      cond_prev_reg <= '0;
      fault_reg <= csf_pkg::FAULT_NONE;
      pulse_cnt_reg <= '0;
      supp_reg <= 1'b0;
      half_reg <= 1'b0;
      dflt_reg <= 1'b1;
      valid_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cond_prev_reg <= cond_now;
      fault_reg <= fault_next;
      pulse_cnt_reg <= pulse_cnt_next;
      supp_reg <= supp_next;
      half_reg <= charging ? !half_reg : 1'b0;
      dflt_reg <= dflt_next;
      valid_prev_reg <= input_valid;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      event_pulse <= 1'b0;
      fault_code <= csf_pkg::FAULT_NONE;
      charge_state <= csf_pkg::CSF_IDLE;
      input_mgmt_flag <= 1'b0;
      discharge_path_on <= 1'b0;
      charge_switch_on <= 1'b0;
      cc_mode <= 1'b0;
      cv_mode <= 1'b0;
      charge_reduce <= 1'b0;
      supplement_on <= 1'b0;
      timer_tick <= 1'b0;
      default_mode <= 1'b1;
      use_default_settings <= 1'b0;
      term_current <= csf_pkg::TERM_DEFAULT_UA;
      precharge_current <= csf_pkg::TERM_DEFAULT_UA;
      input_mgmt_mv <= '0;
      input_mgmt_enabled <= 1'b0;
    end else begin
      event_pulse <= pulse_cnt_next != '0;
      fault_code <= fault_next;
      charge_state <= state_next;
      input_mgmt_flag <= mgmt_active;
      discharge_path_on <= dis_next;
      charge_switch_on <= (state_next == csf_pkg::CSF_CC) || (state_next == csf_pkg::CSF_CV);
      cc_mode <= state_next == csf_pkg::CSF_CC;
      cv_mode <= state_next == csf_pkg::CSF_CV;
      charge_reduce <= power_path_loop_active;
      supplement_on <= supp_next;
      timer_tick <= tick_next;
      default_mode <= dflt_next;
      use_default_settings <= use_dflt;
      term_current <= term_sel;
      precharge_current <= term_sel;
      input_mgmt_mv <= mgmt_en ? mgmt_mv : '0;
      input_mgmt_enabled <= mgmt_en;
    end
  end
endmodule
`default_nettype wire

// [test/csf_host_model.sv]
`default_nettype none
module csf_host_model (
  input wire logic core_clk,
  input wire logic do_read,
  input wire logic do_write,
  output logic fault_read,
  output logic host_write
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each request is copied to its strobe one cycle later, for as many cycles as it is held, as one register access would.
  always @(posedge core_clk) begin
    fault_read <= do_read;
    host_write <= do_write;
  end
endmodule
`default_nettype wire

// [test/csf_top_assertions.sv]
`default_nettype none
module csf_top_assertions #(
  parameter int unsigned DGL_CYCLES = 4,
  parameter int unsigned PULSE_CYCLES = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic charge_disable_pin,
  input wire logic charge_inhibit_bit,
  input wire logic term_enable,
  input wire logic [3:0] input_mgmt_threshold,
  input wire logic host_write,
  input wire logic reset_bit_write,
  input wire logic fault_read,
  input wire logic event_pulse,
  input wire logic [1:0] fault_code,
  input wire csf_pkg::csf_state_e charge_state,
  input wire logic charge_switch_on,
  input wire logic cc_mode,
  input wire logic cv_mode,
  input wire logic charge_reduce,
  input wire logic supplement_on,
  input wire logic default_mode,
  input wire logic [15:0] term_current,
  input wire logic [15:0] precharge_current,
  input wire logic [12:0] input_mgmt_mv,
  input wire logic input_mgmt_enabled
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [15:0] hi_cnt;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) hi_cnt <= 16'h0;
    else if (event_pulse) hi_cnt <= hi_cnt + 16'h1;
    else hi_cnt <= 16'h0;
  end
  AST_PULSE_LEN: assert property ($fell(event_pulse) |-> hi_cnt == 16'(PULSE_CYCLES))
    else $error("event pulse length wrong");
  AST_PULSE_MAX: assert property (hi_cnt <= 16'(PULSE_CYCLES))
    else $error("event pulse too long");
  AST_CODE_HOLD: assert property (fault_code != 2'h0 && !fault_read |=> fault_code != 2'h0)
    else $error("fault code lost without read");
  AST_MGMT_MV: assert property (!input_mgmt_threshold[3] |=> input_mgmt_enabled &&
    input_mgmt_mv == 13'h1068 + 13'h64 * 13'($past(input_mgmt_threshold[2:0])))
    else $error("input management level wrong");
  AST_MGMT_OFF: assert property (input_mgmt_threshold[3] |=> !input_mgmt_enabled)
    else $error("input management not disabled");
  AST_ONE_LOOP: assert property (!(cc_mode && cv_mode))
    else $error("both charge loops active");
  AST_INHIBIT: assert property (charge_inhibit_bit [*6] |-> !charge_switch_on)
    else $error("charging while inhibited");
  AST_PIN_OFF: assert property (charge_disable_pin [*6] |-> !charge_switch_on)
    else $error("charging while pin disables");
  AST_DONE: assert property ($rose(charge_state == csf_pkg::CSF_DONE) |->
    term_enable && !charge_reduce && !supplement_on) else $error("termination not allowed");
  AST_DONE_OFF: assert property ((charge_state == csf_pkg::CSF_DONE) [*2] |->
    !charge_switch_on) else $error("switch on after termination");
  AST_DEF_SET: assert property (reset_bit_write |=> default_mode)
    else $error("default mode not entered");
  AST_DEF_CLR: assert property (host_write && !reset_bit_write |=> !default_mode)
    else $error("default mode not left");
  AST_PRE_EQ: assert property (precharge_current == term_current)
    else $error("precharge differs from termination");
  AST_SPAN: assert property (term_current >= csf_pkg::TERM_MIN_UA &&
    term_current <= csf_pkg::TERM_MAX_UA) else $error("termination current out of span");
endmodule
bind csf_top csf_top_assertions #(.DGL_CYCLES(DGL_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) chk_inst (
  .core_clk(core_clk), .resetn(resetn), .charge_disable_pin(charge_disable_pin),
  .charge_inhibit_bit(charge_inhibit_bit), .term_enable(term_enable),
  .input_mgmt_threshold(input_mgmt_threshold), .host_write(host_write),
  .reset_bit_write(reset_bit_write), .fault_read(fault_read), .event_pulse(event_pulse),
  .fault_code(fault_code), .charge_state(charge_state), .charge_switch_on(charge_switch_on),
  .cc_mode(cc_mode), .cv_mode(cv_mode), .charge_reduce(charge_reduce),
  .supplement_on(supplement_on), .default_mode(default_mode), .term_current(term_current),
  .precharge_current(precharge_current), .input_mgmt_mv(input_mgmt_mv),
  .input_mgmt_enabled(input_mgmt_enabled));
`default_nettype wire

// [test/testbench.sv]
`default_nettype none
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t %s", $time, m); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, resetn = 1'b0, pin = 1'b0, inh = 1'b1, ten = 1'b1, dto = 1'b0;
  logic rbw = 1'b0, cgnd = 1'b0, do_rd = 1'b0, do_wr = 1'b0, rd, hw;
  logic ep, mf, dp, sw, cc, cv, red, sup, dm, uds, me, tick;
  logic [3:0] thr = 4'h0;
  logic [1:0] fc;
  logic [15:0] tc, pc, pts = 16'h0bb8;
  logic [12:0] mv;
  csf_pkg::csf_comp_s c = '0, b;
  csf_pkg::csf_state_e st;
  int n_fail = 0, check_count = 0, cyc = 0;
  csf_host_model csf_host_model_inst (.core_clk(core_clk), .do_read(do_rd), .do_write(do_wr),
    .fault_read(rd), .host_write(hw));
  csf_top #(.DGL_CYCLES(4), .PULSE_CYCLES(8)) csf_top_inst (.core_clk(core_clk),
    .resetn(resetn), .comp_raw(c), .charge_disable_pin(pin), .charge_inhibit_bit(inh),
    .term_enable(ten), .double_timer_option(dto), .input_mgmt_threshold(thr),
    .host_write(hw), .reset_bit_write(rbw), .fault_read(rd), .charge_current_pin_gnd(cgnd),
    .input_limit_pin_gnd(1'b0), .term_pin_gnd(1'b0), .pre_term_setting(pts),
    .term_current_external(16'h1388), .event_pulse(ep), .fault_code(fc), .charge_state(st),
    .input_mgmt_flag(mf), .discharge_path_on(dp), .charge_switch_on(sw), .cc_mode(cc),
    .cv_mode(cv), .charge_reduce(red), .supplement_on(sup), .timer_tick(tick),
    .default_mode(dm), .use_default_settings(uds), .term_current(tc), .precharge_current(pc),
    .input_mgmt_mv(mv), .input_mgmt_enabled(me));
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic s(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic np(input int n, input logic tk, output int k);
    k = 0;
    repeat (n) begin
      @(negedge core_clk);
      k += int'((tk ? tick : ep) === 1'b1);
    end
  endtask
  task automatic rdf();
    @(posedge core_clk);
    do_rd <= 1'b1;
    @(posedge core_clk);
    do_rd <= 1'b0;
    s(3);
  endtask
  task automatic t_charge();
    @(posedge core_clk);
    c.in_above_uvlo <= 1'b1;
    c.in_above_bat_slp <= 1'b1;
    s(12);
    `CHK({st, dp}, {csf_pkg::CSF_INHIBIT, 1'b0}, "inhibit")
    @(posedge core_clk);
    inh <= 1'b0;
    s(8);
    `CHK({st, sw, cc}, {csf_pkg::CSF_CC, 2'h3}, "cc")
    @(posedge core_clk);
    c.bat_at_reg <= 1'b1;
    c.cur_at_term <= 1'b1;
    c.bat_above_rechg <= 1'b1;
    c.mid_below_power_path_loop <= 1'b1;
    s(12);
    `CHK({st, red, cv, cc}, {csf_pkg::CSF_CV, 3'h6}, "cv held")
    @(posedge core_clk);
    c.mid_below_power_path_loop <= 1'b0;
    s(12);
    `CHK({st, sw}, {csf_pkg::CSF_DONE, 1'b0}, "done")
    @(posedge core_clk);
    pin <= 1'b1;
    c.bat_at_reg <= 1'b0;
    c.cur_at_term <= 1'b0;
    s(12);
    `CHK(st, csf_pkg::CSF_INHIBIT, "pin off")
    @(posedge core_clk);
    pin <= 1'b0;
    s(8);
    `CHK(st, csf_pkg::CSF_CC, "pin on")
    $display("test charge done");
  endtask
  task automatic t_fault(input csf_pkg::csf_comp_s bad, input logic [1:0] code,
      input csf_pkg::csf_state_e sx);
    csf_pkg::csf_comp_s good;
    int k;
    good = c;
    @(posedge core_clk);
    c <= bad;
    np(40, 1'b0, k);
    `CHK(k, 8, "pulse count")
    `CHK({fc, st}, {code, sx}, "fault")
    `CHK(dp | (code == csf_pkg::FAULT_UVLO), 1'b1, "discharge")
    rdf();
    `CHK(fc, code, "read while present")
    @(posedge core_clk);
    c <= good;
    s(12);
    `CHK(fc, code, "held until read")
    rdf();
    `CHK({fc, st}, {csf_pkg::FAULT_NONE, csf_pkg::CSF_CC}, "cleared")
    $display("test fault %0d done", code);
  endtask
  task automatic t_mgmt();
    int k;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      thr <= {1'b0, 3'(i)};
      s(3);
      `CHK({me, mv}, {1'b1, 13'h1068 + 13'h64 * 13'(i)}, "level")
    end
    @(posedge core_clk);
    c.in_at_mgmt <= 1'b1;
    dto <= 1'b1;
    s(12);
    `CHK(mf, 1'b1, "limit flag")
    np(8, 1'b1, k);
    `CHK(k, 4, "slow timer")
    @(posedge core_clk);
    c.in_at_mgmt <= 1'b0;
    thr <= csf_pkg::INMGT_DISABLE;
    s(12);
    `CHK({me, mf}, 2'h0, "disabled")
    np(8, 1'b1, k);
    `CHK(k, 8, "full timer")
    $display("test mgmt done");
  endtask
  task automatic t_modes();
    int k;
    `CHK({dm, tc, pc}, {1'b1, 16'h1388, 16'h1388}, "external term")
    @(posedge core_clk);
    do_wr <= 1'b1;
    pts <= 16'h0064;
    @(posedge core_clk);
    do_wr <= 1'b0;
    s(3);
    `CHK(dm, 1'b0, "host mode")
    `CHK({tc, pc}, {csf_pkg::TERM_MIN_UA, csf_pkg::TERM_MIN_UA}, "term floor")
    @(posedge core_clk);
    pts <= 16'hffff;
    s(2);
    `CHK(tc, csf_pkg::TERM_MAX_UA, "term ceiling")
    @(posedge core_clk);
    pts <= 16'h0bb8;
    s(2);
    `CHK({tc, pc}, {16'h0bb8, 16'h0bb8}, "host term")
    @(posedge core_clk);
    rbw <= 1'b1;
    cgnd <= 1'b1;
    @(posedge core_clk);
    rbw <= 1'b0;
    s(3);
    `CHK({dm, uds}, 2'h3, "default mode")
    `CHK({tc, pc}, {csf_pkg::TERM_DEFAULT_UA, csf_pkg::TERM_DEFAULT_UA}, "default term")
    @(posedge core_clk);
    c.mid_below_power_path_loop <= 1'b1;
    c.chg_cur_zero <= 1'b1;
    c.mid_below_bsup1 <= 1'b1;
    s(12);
    `CHK({red, sup}, 2'h3, "supplement")
    np(8, 1'b1, k);
    `CHK(k, 4, "supplement timer")
    @(posedge core_clk);
    c.mid_below_bsup1 <= 1'b0;
    s(12);
    `CHK(sup, 1'b1, "hysteresis")
    @(posedge core_clk);
    c.mid_above_bsup2 <= 1'b1;
    s(12);
    `CHK(sup, 1'b0, "supplement end")
    $display("test modes done");
  endtask
  initial begin
    s(3);
    `CHK({dm, tc, st, ep}, {1'b1, csf_pkg::TERM_DEFAULT_UA, csf_pkg::CSF_IDLE, 1'b0},
      "reset")
    @(posedge core_clk);
    resetn <= 1'b1;
    s(2);
    t_charge();
    b = c;
    b.in_above_ovp = 1'b1;
    t_fault(b, csf_pkg::FAULT_OVP, csf_pkg::CSF_FAULT);
    b = c;
    b.in_above_uvlo = 1'b0;
    t_fault(b, csf_pkg::FAULT_UVLO, csf_pkg::CSF_FAULT);
    b = c;
    b.in_above_bat_slp = 1'b0;
    t_fault(b, csf_pkg::FAULT_SLEEP, csf_pkg::CSF_SLEEP);
    t_mgmt();
    t_modes();
    end_of_test();
  end
endmodule
`default_nettype wire
